// ===== verilog/stepper_pwm_ctrl.sv
/*
  Motor driver controller: static control lines, two reference DAC codes,
  four 8-bit speed PWM channels and a step pulse generator with ramped,
  single and counted modes, all set over an AHB-Lite register port.
  Assumes one 125 MHz clock, a single AHB-Lite master on the same clock and
  an external DAC that converts each 12-bit code to 0..2.5 V.
*/
// Our own choices: the address map and register access over AHB-Lite.
// Summary of operation
// - Each static control line follows its register bit, high when set.
// - Decay line driven only high or low; floating comes from the jumper only.
// - Two 12-bit reference codes 0..4095 map linearly onto 0..2.5 V.
// - PWM duty follows an 8-bit setting; 0 never high, 255 always high.
// - PWM period gives about 31.25 kHz whatever the duty setting; the code uses 4080 cycles, 30.64 kHz.
// - In enable mode each bridge enable line carries its own PWM.
// - In four-input mode each bridge input line has its own PWM.
// - Reported duty is integer percent, setting times 100 over 255.
// - Stepping needs bridge on low, low-power and clear lines high.
// - Free-running stepping always starts at 62 pulses per second.
// - Each speed update adds the 8-bit acceleration increment to the rate.
// - Speed updates are spaced by an 8-bit time base in milliseconds.
// - Rate stops rising at the target and stays there.
// - Stop request ramps down by the same steps to minimum, then halts.
// - Start command begins stepping; the same command again stops it.
// - New target rate accepted only while free-running stepping is active.
// - Single-step command gives exactly one rising edge, then idles.
// - Counted move issues exactly the requested pulses at target rate, then stops.
// - Counted moves run at constant rate with no ramp.
module stepper_pwm_ctrl
  import stepper_pkg::*;
#(
  parameter int unsigned P_MS_CYCLES = MS_CYCLES
)
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // Static driver control lines
  output logic o_low_power_request_n,
  output logic o_driver_clear_n,
  output logic o_bridge_on_active_low,
  output logic o_direction,
  output logic o_decay_select,
  output logic [2:0] o_microstep_select,
  // Step and bridge lines
  output logic o_step,
  output logic [1:0] o_bridge_enable,
  output logic [3:0] o_bridge_input_line,
  // Reference DAC codes
  output logic [DAC_W-1:0] o_ref_level_first_pair,
  output logic [DAC_W-1:0] o_ref_level_second_pair
);

  localparam int unsigned MS_W = $clog2(P_MS_CYCLES);
  localparam int unsigned PRE_W = $clog2(PWM_PRESC);

  // Bus state
  logic wr_pend_q, rd_pend_q, ready_q;
  logic [7:0] addr_q;
  logic [31:0] rdata_q;
  // Registers
  logic [15:0] ctrl_q;
  logic [2*DAC_W-1:0] ref_q;
  logic [4*DUTY_W-1:0] duty_q;
  logic [15:0] rate_reg_q, prof_q, count_q;
  // Line outputs
  logic [1:0] en_q;
  logic [3:0] in_q;
  // PWM timing
  logic [PRE_W-1:0] pre_q;
  logic [DUTY_W-1:0] slot_q;
  // Step engine
  step_state_e st_q, st_d;
  logic [15:0] rate_q, rate_d, tgt_q, tgt_d, pulses_q, pulses_d, move_q, move_d;
  logic [STEP_ACC_W-1:0] acc_q, acc_d;
  logic step_q, step_d;
  logic [7:0] tb_q, tb_d;
  logic [$clog2(SINGLE_CYCLES)-1:0] wid_q, wid_d;
  logic [MS_W-1:0] ms_q;

  // Address decode and write strobes
  wire addr_ok = i_hsel & i_htrans[1] & i_hready;
  wire rd_req = addr_ok & ~i_hwrite;
  wire wr_req = addr_ok & i_hwrite & (i_hsize == HSIZE_WORD);
  wire we_ctrl = wr_pend_q & (addr_q == ADDR_CTRL);
  wire we_ref = wr_pend_q & (addr_q == ADDR_REF);
  wire we_duty = wr_pend_q & (addr_q == ADDR_DUTY);
  wire we_rate = wr_pend_q & (addr_q == ADDR_RATE);
  wire we_prof = wr_pend_q & (addr_q == ADDR_PROF);
  wire we_count = wr_pend_q & (addr_q == ADDR_COUNT);
  wire we_cmd = wr_pend_q & (addr_q == ADDR_CMD);
  wire cmd_go = we_cmd & i_hwdata[CMD_GO];
  wire cmd_upd = we_cmd & i_hwdata[CMD_UPD];
  wire cmd_single = we_cmd & i_hwdata[CMD_SINGLE];
  wire cmd_move = we_cmd & i_hwdata[CMD_MOVE];

  // Driver must be awake, out of clear and bridge on before any step
  wire drv_ready = ~ctrl_q[CTRL_BRIDGE] & ctrl_q[CTRL_LOWPWR] & ctrl_q[CTRL_CLEAR];
  wire four_mode = ctrl_q[CTRL_FOUR];
  wire [7:0] accel = prof_q[7:0];
  wire [7:0] tbase = prof_q[15:8];

  // PWM channels and their percentage readback
  logic [3:0] pwm;
  logic [4*PCT_W-1:0] pct;
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_pwm
      wire [DUTY_W-1:0] duty = duty_q[g*DUTY_W +: DUTY_W];
      // Slots run 0..254, so 255 stays high and 0 never rises
      assign pwm[g] = duty > slot_q;
      assign pct[g*PCT_W +: PCT_W] = PCT_W'((16'(duty) * PCT_FULL) / DUTY_FULL);
    end
  endgenerate

  wire pre_wrap = (pre_q == PRE_W'(PWM_PRESC - 1));
  wire slot_wrap = (slot_q == DUTY_W'(PWM_SLOTS - 1));

  // Millisecond tick and ramp timing
  wire ms_tick = (ms_q == MS_W'(P_MS_CYCLES - 1));
  wire ramp_tick = ms_tick & ({1'b0, tb_q} + 9'h001 >= {1'b0, tbase});
  wire [STEP_ACC_W-1:0] acc_sum = acc_q + STEP_ACC_W'(rate_q);
  wire flip = (acc_sum >= STEP_HALF);
  wire [16:0] up_sum = {1'b0, rate_q} + {9'h000, accel};
  wire [16:0] dn_floor = {1'b0, MIN_RATE} + {9'h000, accel};

  // Read data mux
  logic [31:0] rd_mux;
  always_comb
  begin
    case (addr_q)
      ADDR_CTRL: rd_mux = {16'h0000, ctrl_q};
      ADDR_REF: rd_mux = {4'h0, ref_q[2*DAC_W-1:DAC_W], 4'h0, ref_q[DAC_W-1:0]};
      ADDR_DUTY: rd_mux = duty_q;
      ADDR_PCT: rd_mux = {1'b0, pct[27:21], 1'b0, pct[20:14], 1'b0, pct[13:7], 1'b0, pct[6:0]};
      ADDR_RATE: rd_mux = {16'h0000, rate_reg_q};
      ADDR_PROF: rd_mux = {16'h0000, prof_q};
      ADDR_COUNT: rd_mux = {pulses_q, count_q};
      ADDR_STAT: rd_mux = {10'h000, drv_ready, step_q, (st_q == ST_SINGLE), (st_q == ST_COUNT),
        (st_q == ST_DECEL), (st_q == ST_RUN), rate_q};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Step engine next state
  always_comb
  begin
    st_d = st_q;
    rate_d = rate_q;
    tgt_d = tgt_q;
    acc_d = flip ? acc_sum - STEP_HALF : acc_sum;
    step_d = step_q;
    pulses_d = pulses_q;
    move_d = move_q;
    tb_d = tb_q;
    wid_d = wid_q;
    if (st_q == ST_RUN || st_q == ST_DECEL)
    begin
      tb_d = ramp_tick ? 8'h00 : (ms_tick ? tb_q + 8'h01 : tb_q);
      if (flip)
        step_d = ~step_q;
    end
    case (st_q)
      ST_IDLE:
      begin
        step_d = 1'b0;
        acc_d = '0;
        if (cmd_go && drv_ready)
        begin
          rate_d = MIN_RATE;
          tgt_d = rate_reg_q;
          tb_d = 8'h00;
          st_d = ST_RUN;
        end
        else if (cmd_single && drv_ready)
        begin
          step_d = 1'b1;
          wid_d = '0;
          st_d = ST_SINGLE;
        end
        else if (cmd_move && drv_ready && count_q != 16'h0000)
        begin
          rate_d = rate_reg_q;
          move_d = count_q;
          pulses_d = 16'h0000;
          st_d = ST_COUNT;
        end
      end
      ST_RUN:
      begin
        if (cmd_upd)
          tgt_d = rate_reg_q;
        if (cmd_go)
          st_d = ST_DECEL;
        else if (ramp_tick)
          rate_d = (up_sum >= {1'b0, tgt_q}) ? tgt_q : up_sum[15:0];
      end
      ST_DECEL:
      begin
        if (ramp_tick)
        begin
          if (rate_q <= MIN_RATE)
          begin
            st_d = ST_IDLE;
            step_d = 1'b0;
          end
          else
            rate_d = ({1'b0, rate_q} <= dn_floor) ? MIN_RATE : rate_q - {8'h00, accel};
        end
      end
      ST_COUNT:
      begin
        if (cmd_go)
        begin
          st_d = ST_IDLE;
          step_d = 1'b0;
        end
        else if (flip)
        begin
          if (!step_q)
          begin
            step_d = 1'b1;
            pulses_d = pulses_q + 16'h0001;
          end
          else
          begin
            step_d = 1'b0;
            if (pulses_q == move_q)
              st_d = ST_IDLE;
          end
        end
      end
      ST_SINGLE:
      begin
        wid_d = wid_q + 1'b1;
        if (wid_q == $bits(wid_q)'(SINGLE_CYCLES - 1))
        begin
          step_d = 1'b0;
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // Bus slave: writes take no wait state, reads one so data reflects prior writes
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      ready_q <= 1'b1;
      addr_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_q <= wr_req;
      rd_pend_q <= rd_req;
      ready_q <= ~rd_req;
      if (addr_ok)
        addr_q <= i_haddr[7:0];
      if (rd_pend_q)
        rdata_q <= rd_mux;
    end
  end

  // Software registers
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ctrl_q <= CTRL_RST;
      ref_q <= '0;
      duty_q <= '0;
      rate_reg_q <= RATE_RST;
      prof_q <= PROF_RST;
      count_q <= COUNT_RST;
    end
    else
    begin
      if (we_ctrl)
        ctrl_q <= i_hwdata[15:0];
      if (we_ref)
        ref_q <= {i_hwdata[27:16], i_hwdata[11:0]};
      if (we_duty)
        duty_q <= i_hwdata;
      if (we_rate)
        rate_reg_q <= i_hwdata[15:0];
      if (we_prof)
        prof_q <= i_hwdata[15:0];
      if (we_count)
        count_q <= i_hwdata[15:0];
    end
  end

  // PWM timebase and bridge line drive
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pre_q <= '0;
      slot_q <= '0;
      en_q <= 2'h0;
      in_q <= 4'h0;
    end
    else
    begin
      pre_q <= pre_wrap ? '0 : pre_q + 1'b1;
      if (pre_wrap)
        slot_q <= slot_wrap ? '0 : slot_q + 1'b1;
      en_q <= four_mode ? ctrl_q[CTRL_EN +: 2] : pwm[1:0];
      in_q <= four_mode ? pwm : ctrl_q[CTRL_IN +: 4];
    end
  end

  // Step engine registers
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_q <= ST_IDLE;
      rate_q <= MIN_RATE;
      tgt_q <= MIN_RATE;
      acc_q <= '0;
      step_q <= 1'b0;
      pulses_q <= 16'h0000;
      move_q <= 16'h0000;
      tb_q <= 8'h00;
      wid_q <= '0;
      ms_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      rate_q <= rate_d;
      tgt_q <= tgt_d;
      acc_q <= acc_d;
      step_q <= step_d;
      pulses_q <= pulses_d;
      move_q <= move_d;
      tb_q <= tb_d;
      wid_q <= wid_d;
      ms_q <= ms_tick ? '0 : ms_q + 1'b1;
    end
  end

  assign o_hrdata = rdata_q;
  assign o_hreadyout = ready_q;
  assign o_hresp = 1'b0;
  assign o_low_power_request_n = ctrl_q[CTRL_LOWPWR];
  assign o_driver_clear_n = ctrl_q[CTRL_CLEAR];
  assign o_bridge_on_active_low = ctrl_q[CTRL_BRIDGE];
  assign o_direction = ctrl_q[CTRL_DIR];
  assign o_decay_select = ctrl_q[CTRL_DECAY];
  assign o_microstep_select = ctrl_q[CTRL_USM +: 3];
  assign o_step = step_q;
  assign o_bridge_enable = en_q;
  assign o_bridge_input_line = in_q;
  assign o_ref_level_first_pair = ref_q[DAC_W-1:0];
  assign o_ref_level_second_pair = ref_q[2*DAC_W-1:DAC_W];

  // Checks
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  logic [12:0] per_q;
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      per_q <= '0;
    else
      per_q <= (pre_wrap && slot_wrap) ? '0 : per_q + 13'h0001;
  end

  property p_ctrl_lines;
    wr_pend_q && addr_q == ADDR_CTRL |=> o_driver_clear_n == $past(i_hwdata[CTRL_CLEAR])
      && o_low_power_request_n == $past(i_hwdata[CTRL_LOWPWR]);
  endproperty
  a_ctrl_lines: assert property (p_ctrl_lines) else $error("control line mismatch");
  property p_pwm_period;
    pre_wrap && slot_wrap && $past(per_q) != 13'h0000 |-> per_q == 13'(PWM_PERIOD - 1);
  endproperty
  a_pwm_period: assert property (p_pwm_period) else $error("pwm period wrong");
  property p_duty_full;
    !four_mode && $past(!four_mode) && $past(duty_q[7:0]) == 8'hff |-> o_bridge_enable[0];
  endproperty
  a_duty_full: assert property (p_duty_full) else $error("full duty not high");
  property p_pct;
    16'(pct[6:0]) * DUTY_FULL <= 16'(duty_q[7:0]) * PCT_FULL
      && 16'(duty_q[7:0]) * PCT_FULL < (16'(pct[6:0]) + 16'h0001) * DUTY_FULL;
  endproperty
  a_pct: assert property (p_pct) else $error("duty percent wrong");
  property p_start_min;
    st_q == ST_IDLE ##1 st_q == ST_RUN |-> rate_q == MIN_RATE && $past(drv_ready);
  endproperty
  a_start_min: assert property (p_start_min) else $error("bad start");
  property p_no_overshoot;
    // A speed update may lower the target under the rate; the clamp follows at the next tick
    st_q == ST_RUN && $stable(tgt_q) && rate_q <= tgt_q |=> rate_q <= $past(tgt_q);
  endproperty
  a_no_overshoot: assert property (p_no_overshoot) else $error("rate above target");
  property p_tgt_run_only;
    $changed(tgt_q) |-> $past(st_q) == ST_RUN || $past(st_q) == ST_IDLE && st_q == ST_RUN;
  endproperty
  a_tgt_run_only: assert property (p_tgt_run_only) else $error("target changed idle");
  property p_single;
    st_q == ST_IDLE && st_d == ST_SINGLE |=> o_step [*8] ##[1:300] !o_step && st_q == ST_IDLE;
  endproperty
  a_single: assert property (p_single) else $error("single pulse bad");
  property p_count_done;
    st_q == ST_COUNT && st_d == ST_IDLE && !cmd_go |-> pulses_q == move_q;
  endproperty
  a_count_done: assert property (p_count_done) else $error("pulse count wrong");
  property p_count_flat;
    st_q == ST_COUNT ##1 st_q == ST_COUNT |-> $stable(rate_q);
  endproperty
  a_count_flat: assert property (p_count_flat) else $error("rate ramped in move");
  property p_idle_low;
    st_q == ST_IDLE ##1 st_q == ST_IDLE |-> !o_step;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("step high while idle");

endmodule

// ===== inc/stepper_pkg.sv
/*
  Shared constants for the stepper pulse and PWM controller: register map,
  field positions, reset values, timing figures and the stepping state type.
  Assumes a single 125 MHz system clock and a 32-bit AHB-Lite register port.
*/
package stepper_pkg;

  // Clock and time figures
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned MS_NS = 1_000_000;
  localparam int unsigned MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned SINGLE_PULSE_NS = 2_000;
  localparam int unsigned SINGLE_CYCLES = SINGLE_PULSE_NS / CLK_PERIOD_NS;
  localparam int unsigned PWM_FREQ_HZ = 31_250;
  localparam int unsigned PWM_SLOTS = 255;
  // Nearest whole prescale; the resulting period is 4080 cycles (30.64 kHz)
  localparam int unsigned PWM_PRESC =
    (CLK_HZ + (PWM_FREQ_HZ * PWM_SLOTS) / 2) / (PWM_FREQ_HZ * PWM_SLOTS);
  localparam int unsigned PWM_PERIOD = PWM_PRESC * PWM_SLOTS;
  // Step output toggles twice per step, so the accumulator wraps at half a second
  localparam int unsigned STEP_ACC_W = 27;
  localparam logic [26:0] STEP_HALF = 27'(CLK_HZ / 2);

  // Step rate and data widths
  localparam logic [15:0] MIN_RATE = 16'h003e;
  localparam int unsigned DAC_W = 12;
  localparam int unsigned DUTY_W = 8;
  localparam int unsigned PCT_W = 7;
  localparam logic [15:0] PCT_FULL = 16'h0064;
  localparam logic [15:0] DUTY_FULL = 16'h00ff;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_REF = 8'h04;
  localparam logic [7:0] ADDR_DUTY = 8'h08;
  localparam logic [7:0] ADDR_PCT = 8'h0c;
  localparam logic [7:0] ADDR_RATE = 8'h10;
  localparam logic [7:0] ADDR_PROF = 8'h14;
  localparam logic [7:0] ADDR_COUNT = 8'h18;
  localparam logic [7:0] ADDR_CMD = 8'h1c;
  localparam logic [7:0] ADDR_STAT = 8'h20;

  // Control register fields
  localparam int unsigned CTRL_LOWPWR = 0;
  localparam int unsigned CTRL_CLEAR = 1;
  localparam int unsigned CTRL_BRIDGE = 2;
  localparam int unsigned CTRL_DIR = 3;
  localparam int unsigned CTRL_DECAY = 4;
  localparam int unsigned CTRL_USM = 5;
  localparam int unsigned CTRL_FOUR = 8;
  localparam int unsigned CTRL_IN = 9;
  localparam int unsigned CTRL_EN = 13;
  localparam logic [15:0] CTRL_RST = 16'h0004;

  // Command register bits
  localparam int unsigned CMD_GO = 0;
  localparam int unsigned CMD_UPD = 1;
  localparam int unsigned CMD_SINGLE = 2;
  localparam int unsigned CMD_MOVE = 3;

  // Other reset values
  localparam logic [15:0] RATE_RST = 16'h003e;
  localparam logic [15:0] PROF_RST = 16'h0000;
  localparam logic [15:0] COUNT_RST = 16'h0000;

  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_DECEL, ST_COUNT, ST_SINGLE} step_state_e;

endpackage

// ===== sim/motor_drv_model.sv
/*
  Behavioural motor driver seen from the step line: counts steps and times
  the last high half of the step output.
  Assumes the controller clock and a step line that the controller drives.
*/
module motor_drv_model
(
  // Clock
  input wire logic i_clk,
  // Step line from the controller
  input wire logic i_step,
  // Observations
  output int o_steps,
  output int o_hi_len
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last_q;
  int run_q;
  initial
  begin
    o_steps = 0;
    o_hi_len = 0;
    last_q = 1'b0;
    run_q = 0;
  end
  // Position moves on rising edges only; a falling edge leaves it alone
  always @(posedge i_clk)
  begin
    last_q <= i_step;
    if (i_step === 1'b1 && last_q !== 1'b1) o_steps <= o_steps + 1;
    if (i_step === 1'b1) run_q <= run_q + 1;
    else if (last_q === 1'b1)
    begin
      o_hi_len <= run_q;
      run_q <= 0;
    end
  end
endmodule

// ===== sim/stepper_pwm_ctrl_tb.sv
/*
  Self-checking bench for the stepper and PWM controller: an AHB-Lite master,
  a shadow register model and the motor driver model on the step line.
  Assumes one 125 MHz clock and a shortened millisecond tick of 20 cycles.
*/
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin mismatches++; \
  $display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end
module stepper_pwm_ctrl_tb;
  import stepper_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, hsel, hwrite, hreadyout, hresp, lp_n, clr_n, bon, dir, decay, step;
  logic [31:0] haddr, hwdata, hrdata, v, d;
  logic [1:0] htrans, ben;
  logic [2:0] hsize, usm;
  logic [3:0] bil;
  logic [DAC_W-1:0] ref1, ref2;
  logic [31:0] shadow [int];
  int mismatches, n_checks, steps, hi_len, s0, hc[6];
  stepper_pwm_ctrl #(.P_MS_CYCLES(20)) uut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout),
    .o_hresp(hresp), .o_low_power_request_n(lp_n), .o_driver_clear_n(clr_n),
    .o_bridge_on_active_low(bon), .o_direction(dir), .o_decay_select(decay),
    .o_microstep_select(usm), .o_step(step), .o_bridge_enable(ben),
    .o_bridge_input_line(bil), .o_ref_level_first_pair(ref1),
    .o_ref_level_second_pair(ref2));
  motor_drv_model drv (.i_clk(clk), .i_step(step), .o_steps(steps), .o_hi_len(hi_len));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic wrap_up();
    if (mismatches == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  function automatic logic [31:0] wmask(input logic [7:0] a);
    case (a)
      ADDR_CTRL: return 32'h0000_7fff;
      ADDR_REF: return 32'h0fff_0fff;
      ADDR_DUTY: return 32'hffff_ffff;
      default: return 32'h0000_ffff;
    endcase
  endfunction
  // Holds each phase until hready is seen high; read data taken at that edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    int n;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    n = 0;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) mismatches++;
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    n = 0;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) mismatches++;
    rd = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    bus(1'b1, a, wd, x);
    if (shadow.exists(a)) shadow[a] = wd & wmask(a);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] x);
    bus(1'b0, a, 32'h0, x);
  endtask
  task automatic chk_reg(input logic [7:0] a);
    logic [31:0] x;
    rd(a, x);
    `CHK("register", shadow[a], x & wmask(a))
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Polls a status bit until it clears, bounded by the number of tries
  task automatic wait_clear(input int b, input int tries);
    do begin tick(100); rd(ADDR_STAT, v); tries--; end while (v[b] !== 1'b0 && tries > 0);
    if (v[b] !== 1'b0) mismatches++;
  endtask
  initial
  begin
    repeat (60000) @(posedge clk);
    mismatches++;
    wrap_up();
  end
  initial
  begin
    {rst_n, hsel, hwrite, haddr, hwdata, htrans} = '0;
    hsize = HSIZE_WORD;
    mismatches = 0;
    n_checks = 0;
    v = $urandom(32'h0e5e);
    shadow[ADDR_CTRL] = CTRL_RST;
    shadow[ADDR_RATE] = RATE_RST;
    shadow[ADDR_REF] = 0;
    shadow[ADDR_DUTY] = 0;
    shadow[ADDR_PROF] = PROF_RST;
    shadow[ADDR_COUNT] = COUNT_RST;
    tick(12);
    rst_n <= 1'b1;
    tick(1);
    `CHK("bridge idle", 1'b1, bon)
    foreach (shadow[a]) chk_reg(a[7:0]);
    rd(8'h24, v);
    `CHK("unmapped", 32'h0, v)
    repeat (4)
    begin
      d = $urandom & 32'h7fff;
      wr(ADDR_CTRL, d);
      chk_reg(ADDR_CTRL);
      `CHK("ctrl lines", d[7:0], {usm, decay, dir, bon, clr_n, lp_n})
      if (d[CTRL_FOUR]) `CHK("static en", d[14:13], ben)
      else `CHK("static in", d[12:9], bil)
    end
    d = $urandom;
    wr(ADDR_REF, d);
    // The write lands at the edge that ends the task; let the lines settle
    tick(1);
    `CHK("ref a", d[11:0], ref1)
    `CHK("ref b", d[27:16], ref2)
    d = {8'($urandom), 8'($urandom), 8'h00, 8'hff};
    wr(ADDR_DUTY, d);
    rd(ADDR_PCT, v);
    for (int k = 0; k < 4; k++) `CHK("percent", 7'(d[8*k+:8] * 100 / 255), v[8*k+:7])
    for (int m = 0; m < 2; m++)
    begin
      wr(ADDR_CTRL, 32'h0004 | (m << CTRL_FOUR));
      tick(8);
      hc = '{default: 0};
      repeat (PWM_PERIOD)
      begin
        @(posedge clk);
        for (int j = 0; j < 4; j++) hc[j] += (bil[j] === 1'b1);
        for (int j = 0; j < 2; j++) hc[4+j] += (ben[j] === 1'b1);
      end
      for (int j = 0; j < 4; j++)
        if (m == 1) `CHK("pwm in", d[8*j+:8] * PWM_PRESC, hc[j])
      for (int j = 0; j < 2; j++)
        if (m == 0) `CHK("pwm en", d[8*j+:8] * PWM_PRESC, hc[4+j])
    end
    s0 = steps;
    wr(ADDR_CMD, 32'h4);
    tick(300);
    `CHK("not ready", s0, steps)
    wr(ADDR_CTRL, 32'h0003);
    wr(ADDR_CMD, 32'h4);
    tick(300);
    `CHK("single", s0 + 1, steps)
    `CHK("single idle", 1'b0, step)
    wr(ADDR_CMD, 32'h8);
    tick(300);
    `CHK("move zero", s0 + 1, steps)
    wr(ADDR_RATE, 32'd50000);
    wr(ADDR_COUNT, 32'd5);
    wr(ADDR_CMD, 32'h8);
    tick(3000);
    rd(ADDR_STAT, v);
    `CHK("move rate", 16'd50000, v[15:0])
    wait_clear(18, 200);
    rd(ADDR_COUNT, v);
    `CHK("move pulses", 16'd5, v[31:16])
    `CHK("move steps", s0 + 6, steps)
    `CHK("half period", 1'b1, hi_len >= 1249 && hi_len <= 1251)
    wr(ADDR_RATE, 32'd20000);
    wr(ADDR_PROF, 32'h01ff);
    wr(ADDR_CMD, 32'h1);
    rd(ADDR_STAT, v);
    `CHK("start rate", 1'b1, v[15:0] === MIN_RATE || v[15:0] === 16'h013d)
    repeat (5)
    begin
      tick(60);
      rd(ADDR_STAT, v);
      `CHK("ramp", 16'h0, (v[15:0] - MIN_RATE) % 16'd255)
    end
    tick(2500);
    rd(ADDR_STAT, v);
    `CHK("target", 16'd20000, v[15:0])
    wr(ADDR_RATE, 32'd10000);
    tick(100);
    rd(ADDR_STAT, v);
    `CHK("no update", 16'd20000, v[15:0])
    wr(ADDR_CMD, 32'h2);
    tick(100);
    rd(ADDR_STAT, v);
    `CHK("update", 16'd10000, v[15:0])
    wr(ADDR_CMD, 32'h1);
    rd(ADDR_STAT, v);
    `CHK("decel", 1'b1, v[17])
    wait_clear(17, 60);
    `CHK("stopped", 2'b00, v[17:16])
    `CHK("step low", 1'b0, step)
    wr(ADDR_CMD, 32'h2);
    rd(ADDR_STAT, v);
    `CHK("halt update", 1'b0, v[16])
    wrap_up();
  end
endmodule
